/* File: mwsc_pkg.sv */
// Purpose: Shared constants and types for the memory wait-state controller.
// Assumes: One board clock; all counts are board-clock cycles.
// Notes:   Region bases and per-region timings are plain defaults for a board map.
package mwsc_pkg;

    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 17;
    localparam int ADDR_W  = ADDR_HI - ADDR_LO + 1;
    localparam int NUM_CS  = 6;
    localparam int NUM_USR = 3;
    localparam int CNT_W   = 5;
    localparam int LANES   = 4;

    // Region order: 0 SRAM, 1 EPROM, 2 I/O, 3..5 user regions.
    localparam logic [2:0] REG_SRAM  = 3'h0;
    localparam logic [2:0] REG_EPROM = 3'h1;
    localparam logic [2:0] REG_IO    = 3'h2;
    localparam logic [2:0] REG_NONE  = 3'h7;

    localparam logic [NUM_CS-1:0][ADDR_W-1:0] CS_BASE = {
        15'h0F03, 15'h0F02, 15'h0F01, 15'h0F00, 15'h0FE0, 15'h0000
    };
    localparam logic [NUM_CS-1:0][ADDR_W-1:0] CS_MASK = {
        15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF
    };

    localparam logic [NUM_CS-1:0][CNT_W-1:0] FIRST_WAIT = {
        5'h04, 5'h04, 5'h04, 5'h06, 5'h04, 5'h02
    };
    localparam logic [NUM_CS-1:0][CNT_W-1:0] WORD_GAP = {
        5'h02, 5'h02, 5'h02, 5'h06, 5'h03, 5'h01
    };

    localparam logic [CNT_W-1:0] CNT_RESET    = 5'h00;
    localparam logic [CNT_W-1:0] CNT_FIRST    = 5'h01;
    localparam logic [CNT_W-1:0] LAUNCH_DELAY = 5'h01;
    localparam logic [CNT_W-1:0] FAULT_AT     = 5'h01;
    localparam logic [CNT_W-1:0] FAULT_END    = 5'h02;
    localparam logic [2:0]       WORDS_SINGLE = 3'h1;
    localparam logic [2:0]       WORDS_BURST  = 3'h4;
    localparam logic [6:0]       PIN_RESET    = 7'h7F;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_FAULT
    } mwsc_state_t;

endpackage : mwsc_pkg

/* File: mwsc_dec_if.sv */
// Purpose: Carries the latched address and chip-select results between decoder and controller.
// Assumes: Decoder is purely combinational.
// Notes:   Selects are active low; enables are low while the decoder drives.
`timescale 1ns/1ps
`default_nettype none
interface mwsc_dec_if;
    import mwsc_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              test_en;
    logic [NUM_USR-1:0] user_en;
    logic [NUM_CS-1:0] sel_n;
    logic [NUM_CS-1:0] oe_n;
    logic              hit;
    logic [2:0]        region;

    modport dec (input addr, test_en, user_en, output sel_n, oe_n, hit, region);
    modport ctl (output addr, test_en, user_en, input sel_n, oe_n, hit, region);
endinterface : mwsc_dec_if
`default_nettype wire

/* File: mwsc_decoder.sv */
// Purpose: Address decoder producing chip selects from the upper address bits.
// Assumes: Address comes straight from the transparent address latch.
// Notes:   No latch-enable qualification, so selects may glitch while the address settles.
`timescale 1ns/1ps
`default_nettype none
module mwsc_decoder (
    mwsc_dec_if.dec dif
);
    import mwsc_pkg::*;

    function automatic logic region_match(input logic [ADDR_W-1:0] a, input int idx);
        region_match = ((a ^ CS_BASE[idx]) & CS_MASK[idx]) == {ADDR_W{1'b0}};
    endfunction : region_match

    logic [NUM_CS-1:0] match;
    logic [NUM_CS-1:0] allow;

    assign allow = {dif.user_en, 3'h7};

    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_cs
            assign match[g]     = region_match(dif.addr, g) & allow[g]; // RULE_01 RULE_02 RULE_03
            assign dif.sel_n[g] = ~match[g];
            assign dif.oe_n[g]  = dif.test_en; // RULE_05
        end
    endgenerate

    assign dif.hit    = |match;
    assign dif.region = match[0] ? REG_SRAM :
                        match[1] ? REG_EPROM :
                        match[2] ? REG_IO :
                        match[3] ? 3'h3 :
                        match[4] ? 3'h4 :
                        match[5] ? 3'h5 : REG_NONE;

endmodule : mwsc_decoder
`default_nettype wire

/* File: mwsc_top.sv */
// Purpose: Wait-state and memory cycle controller with chip-select decoding.
// Assumes: mclk_in is the board clock; processor strobes are active low.
// Notes:   Chip selects and their output enables are combinational; every other output is registered.
// Contract
// RULE_01: Chip selects decode address bits 31 to 17.
// RULE_02: Three spare outputs act as user selects.
// RULE_03: Selects are combinational, ignoring latch enable.
// RULE_04: Memory strobes synchronous, only during transfers.
// RULE_05: Test enable floats all decoder outputs.
// RULE_06: Wait states throttle the read termination.
// RULE_07: Writes reuse the same counter and termination.
// RULE_08: Start on asserting read or write edge.
// RULE_09: Start launches five-bit up counter timing all.
// RULE_10: Counter advances once per board clock edge.
// RULE_11: Counter decode ends cycle, not strobe negation.
// RULE_12: Cycle finish returns machine and counter idle.
// RULE_13: Byte enable launch waits fixed cycle count.
// RULE_14: Burst and select choose read accept pulses.
// RULE_15: Acknowledge ends writes, optionally burst reads.
// RULE_16: First and spacing delays set per region.
// RULE_17: Undecoded address ends with bus fault.
// RULE_18: Processor drops read half cycle after fault.
// RULE_19: One clock edge; unaligned strobe edges ignored.
// RULE_20: Option: both strobes negated clear counter.
// RULE_21: Option: negation detector gates terminations.
// RULE_22: Board clock is inverted processor clock.
// RULE_23: Byte store pulses combine lanes and timing.
// RULE_24: Idle keeps counter zero, terminations negated.
`timescale 1ns/1ps
`default_nettype none
module mwsc_top #(
    parameter logic [mwsc_pkg::NUM_USR-1:0] USER_CS_EN   = 3'h7,
    parameter bit                           ACK_ON_BURST = 1'b1,
    parameter bit                           ASYNC_TERM   = 1'b0,
    parameter bit                           NEG_INTERLOCK = 1'b0
) (
    input  wire logic                            mclk_in,
    input  wire logic                            resetn_in,
    input  wire logic                            ce_in,
    input  wire logic [mwsc_pkg::ADDR_HI:mwsc_pkg::ADDR_LO] address_in,
    input  wire logic                            rd_n_in,
    input  wire logic                            wr_n_in,
    input  wire logic                            burst_n_in,
    input  wire logic [mwsc_pkg::LANES-1:0]      byte_lane_select_n_in,
    input  wire logic                            test_en_in,
    output logic [mwsc_pkg::NUM_CS-1:0]          cs_n_out,
    output logic [mwsc_pkg::NUM_CS-1:0]          cs_oe_n_out,
    output logic                                 read_word_accept_n_out,
    output logic                                 ack_n_out,
    output logic                                 bus_fault_n_out,
    output logic                                 cycle_finish_n_out,
    output logic                                 byte_enable_launch_n_out,
    output logic                                 mem_read_en_n_out,
    output logic                                 mem_write_en_n_out,
    output logic [mwsc_pkg::LANES-1:0]           byte_store_pulse_n_out
);
    import mwsc_pkg::*;

    mwsc_dec_if dif ();

    mwsc_decoder u_dec (
        .dif (dif.dec)
    );

    assign dif.addr    = address_in;
    assign dif.test_en = test_en_in;
    assign dif.user_en = USER_CS_EN;
    // The decoder must answer inside the address phase, so these bypass registers.
    assign cs_n_out    = dif.sel_n;
    assign cs_oe_n_out = dif.oe_n;

    // Pin synchroniser: s1 feeds only s2; a level counts once s2 and s3 agree.
    logic [6:0] pin_raw;
    logic [6:0] s1_r;
    logic [6:0] s2_r;
    logic [6:0] s3_r;
    logic [6:0] lvl_r;
    logic [6:0] lvl_nxt;
    logic [6:0] lvl_q_r;

    assign pin_raw = {byte_lane_select_n_in, burst_n_in, wr_n_in, rd_n_in};
    assign lvl_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & lvl_r); // RULE_19

    always_ff @(posedge mclk_in) begin // RULE_22
        if (!resetn_in) begin
            s1_r    <= PIN_RESET;
            s2_r    <= PIN_RESET;
            s3_r    <= PIN_RESET;
            lvl_r   <= PIN_RESET;
            lvl_q_r <= PIN_RESET;
        end else if (ce_in) begin
            s1_r    <= pin_raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            lvl_r   <= lvl_nxt;
            lvl_q_r <= lvl_r;
        end
    end

    wire              rd_lvl    = lvl_r[0];
    wire              wr_lvl    = lvl_r[1];
    wire              burst_lvl = lvl_r[2];
    wire [LANES-1:0]  lane_n    = lvl_r[6:3];
    wire              rd_fall   = lvl_q_r[0] & ~rd_lvl;
    wire              wr_fall   = lvl_q_r[1] & ~wr_lvl;
    wire              rd_rise   = ~lvl_q_r[0] & rd_lvl;
    wire              wr_rise   = ~lvl_q_r[1] & wr_lvl;

    mwsc_state_t      state_r;
    mwsc_state_t      state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] end_r;
    logic [CNT_W-1:0] end_nxt;
    logic [CNT_W-1:0] gap_r;
    logic [CNT_W-1:0] gap_nxt;
    logic [CNT_W-1:0] hit_at_r;
    logic [CNT_W-1:0] hit_at_nxt;
    logic [CNT_W-1:0] first_r;
    logic [CNT_W-1:0] first_nxt;
    logic [2:0]       words_r;
    logic [2:0]       words_nxt;
    logic             neg_seen_r;
    logic             neg_seen_nxt;

    // Start timing is fetched from the region captured at the asserting edge.
    wire [2:0]       reg_idx   = dif.region;
    wire [CNT_W-1:0] sel_first = dif.hit ? FIRST_WAIT[reg_idx] : CNT_FIRST; // RULE_16
    wire [CNT_W-1:0] sel_gap   = dif.hit ? WORD_GAP[reg_idx] : CNT_FIRST; // RULE_16
    wire             is_burst  = rd_fall & ~burst_lvl;
    wire [2:0]       sel_words = is_burst ? WORDS_BURST : WORDS_SINGLE; // RULE_14
    wire [CNT_W-1:0] gap3      = CNT_W'(sel_gap + (sel_gap << 1));
    wire [CNT_W-1:0] sel_end   = is_burst ? CNT_W'(sel_first + gap3 + 5'h01)
                                          : CNT_W'(sel_first + 5'h01);

    wire start     = (state_r == ST_IDLE) & (rd_fall | wr_fall); // RULE_08
    wire active    = (state_r != ST_IDLE);
    wire mem_cycle = (state_r == ST_READ) | (state_r == ST_WRITE);
    wire finish    = active & (cnt_r == end_r); // RULE_11
    wire both_neg  = ASYNC_TERM & rd_lvl & wr_lvl & mem_cycle; // RULE_20
    wire gate_term = NEG_INTERLOCK & neg_seen_r; // RULE_21

    wire launch_c  = mem_cycle & (cnt_r >= LAUNCH_DELAY) & ~finish; // RULE_13
    wire rwa_c     = (state_r == ST_READ) & (cnt_r == hit_at_r)
                     & (words_r != 3'h0) & ~gate_term; // RULE_06 RULE_14
    wire last_word = (words_r == 3'h1);
    wire ack_c     = ((state_r == ST_WRITE) & (cnt_r == first_r)
                     | ACK_ON_BURST & rwa_c & last_word & (end_r != CNT_W'(first_r + 5'h01)))
                     & ~gate_term; // RULE_07 RULE_15
    wire fault_c   = (state_r == ST_FAULT) & (cnt_r == FAULT_AT); // RULE_17

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        end_nxt      = end_r;
        gap_nxt      = gap_r;
        hit_at_nxt   = hit_at_r;
        first_nxt    = first_r;
        words_nxt    = words_r;
        neg_seen_nxt = neg_seen_r;
        case (state_r)
            ST_IDLE: begin
                cnt_nxt      = CNT_RESET; // RULE_24
                neg_seen_nxt = 1'b0;
                if (start) begin
                    cnt_nxt = CNT_FIRST; // RULE_09
                    if (!dif.hit) begin
                        state_nxt = ST_FAULT; // RULE_17
                        end_nxt   = FAULT_END; // RULE_18
                    end else begin
                        state_nxt  = rd_fall ? ST_READ : ST_WRITE;
                        end_nxt    = sel_end;
                        gap_nxt    = sel_gap;
                        first_nxt  = sel_first;
                        hit_at_nxt = sel_first;
                        words_nxt  = rd_fall ? sel_words : 3'h0;
                    end
                end
            end
            ST_READ, ST_WRITE, ST_FAULT: begin
                cnt_nxt = CNT_W'(cnt_r + 5'h01); // RULE_10
                if (rwa_c) begin
                    hit_at_nxt = CNT_W'(hit_at_r + gap_r);
                    words_nxt  = 3'(words_r - 3'h1);
                end
                if (rd_rise | wr_rise) begin
                    neg_seen_nxt = 1'b1;
                end
                if (finish | both_neg) begin
                    state_nxt = ST_IDLE; // RULE_12
                    cnt_nxt   = CNT_RESET;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            state_r    <= ST_IDLE;
            cnt_r      <= CNT_RESET;
            end_r      <= CNT_RESET;
            gap_r      <= CNT_RESET;
            hit_at_r   <= CNT_RESET;
            first_r    <= CNT_RESET;
            words_r    <= 3'h0;
            neg_seen_r <= 1'b0;
        end else if (ce_in) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            end_r      <= end_nxt;
            gap_r      <= gap_nxt;
            hit_at_r   <= hit_at_nxt;
            first_r    <= first_nxt;
            words_r    <= words_nxt;
            neg_seen_r <= neg_seen_nxt;
        end
    end

    // Outputs lag their counter decode by one edge so that all of them leave flip-flops.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            read_word_accept_n_out   <= 1'b1;
            ack_n_out                <= 1'b1;
            bus_fault_n_out          <= 1'b1;
            cycle_finish_n_out       <= 1'b1;
            byte_enable_launch_n_out <= 1'b1;
            mem_read_en_n_out        <= 1'b1;
            mem_write_en_n_out       <= 1'b1;
            byte_store_pulse_n_out   <= 4'hF;
        end else if (ce_in) begin
            read_word_accept_n_out   <= ~rwa_c; // RULE_14
            ack_n_out                <= ~ack_c; // RULE_15
            bus_fault_n_out          <= ~fault_c; // RULE_17
            cycle_finish_n_out       <= ~(finish | both_neg); // RULE_12
            byte_enable_launch_n_out <= ~launch_c; // RULE_13
            mem_read_en_n_out        <= ~(launch_c & (state_r == ST_READ)); // RULE_04
            mem_write_en_n_out       <= ~(launch_c & (state_r == ST_WRITE)); // RULE_04
            byte_store_pulse_n_out   <= ~({LANES{launch_c & (state_r == ST_WRITE)}}
                                          & ~lane_n); // RULE_23
        end
    end

    property p_idle_quiet;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        (state_r == ST_IDLE) |-> (cnt_r == CNT_RESET);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // RULE_24
        else $error("Counter not zero while idle.");

    property p_idle_terms;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        ($past(state_r) == ST_IDLE) && (state_r == ST_IDLE)
            |-> read_word_accept_n_out && ack_n_out && bus_fault_n_out;
    endproperty
    a_idle_terms: assert property (p_idle_terms) // RULE_24
        else $error("Termination asserted while idle.");

    property p_count_up;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        active && !finish && !both_neg ##1 ce_in |-> cnt_r == CNT_W'($past(cnt_r) + 5'h01);
    endproperty
    a_count_up: assert property (p_count_up) // RULE_10
        else $error("Cycle counter did not advance by one.");

    property p_finish_idle;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        !cycle_finish_n_out |-> (state_r == ST_IDLE) && (cnt_r == CNT_RESET);
    endproperty
    a_finish_idle: assert property (p_finish_idle) // RULE_12
        else $error("Cycle finish did not return to idle.");

    property p_start_runs;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        start ##1 ce_in |-> (state_r != ST_IDLE) && (cnt_r == CNT_FIRST);
    endproperty
    a_start_runs: assert property (p_start_runs) // RULE_08
        else $error("Strobe edge did not start the counter.");

    property p_launch_late;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        $fell(byte_enable_launch_n_out) |-> $past(cnt_r) == LAUNCH_DELAY;
    endproperty
    a_launch_late: assert property (p_launch_late) // RULE_13
        else $error("Byte enable launch at wrong count.");

    property p_fault_undecoded;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        start && !dif.hit ##1 ce_in |-> ##1 !bus_fault_n_out ##1 !cycle_finish_n_out;
    endproperty
    a_fault_undecoded: assert property (p_fault_undecoded) // RULE_17
        else $error("Undecoded cycle not ended by bus fault.");

    property p_read_en_only_read;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        !mem_read_en_n_out |-> $past(state_r) == ST_READ && mem_write_en_n_out;
    endproperty
    a_read_en_only_read: assert property (p_read_en_only_read) // RULE_04
        else $error("Read enable outside a read transfer.");

    property p_store_lanes;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        ($past(lane_n) != 4'hF) && !mem_write_en_n_out
            |-> byte_store_pulse_n_out == $past(lane_n);
    endproperty
    a_store_lanes: assert property (p_store_lanes) // RULE_23
        else $error("Byte store pulses do not match lane selects.");

    property p_write_ack;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        (state_r == ST_IDLE) && wr_fall && dif.hit && !NEG_INTERLOCK && !ASYNC_TERM
            |-> ##[2:8] !ack_n_out;
    endproperty
    a_write_ack: assert property (p_write_ack) // RULE_15
        else $error("Write cycle without acknowledge.");

    property p_test_float;
        @(posedge mclk_in) disable iff (!resetn_in)
        test_en_in |-> cs_oe_n_out == {NUM_CS{1'b1}};
    endproperty
    a_test_float: assert property (p_test_float) // RULE_05
        else $error("Decoder outputs driven in test mode.");

    property p_fault_only_fault;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        !bus_fault_n_out |-> ($past(state_r) == ST_FAULT) && read_word_accept_n_out;
    endproperty
    a_fault_only_fault: assert property (p_fault_only_fault) // RULE_17
        else $error("Bus fault outside an undecoded cycle.");

    property p_accept_in_read;
        @(posedge mclk_in) disable iff (!resetn_in || !ce_in)
        !read_word_accept_n_out |-> ($past(state_r) == ST_READ) && !mem_read_en_n_out;
    endproperty
    a_accept_in_read: assert property (p_accept_in_read) // RULE_06 RULE_14
        else $error("Read accept outside a timed read.");

endmodule : mwsc_top
`default_nettype wire

/* File: mwsc_cpu_model.sv */
// Purpose: Behavioural processor bus unit that starts transfers and reacts to terminations.
// Assumes: Strobes change just after a rising edge; bus-fault release is on the falling edge.
// Notes:   Between transfers the address and lanes toggle, so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module mwsc_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic        wr_in,
    input  wire logic        burst_in,
    input  wire logic        hold_in,
    input  wire logic [14:0] addr_in,
    input  wire logic [3:0]  lanes_in,
    input  wire logic        accept_n_in,
    input  wire logic        ack_n_in,
    input  wire logic        fault_n_in,
    input  wire logic        finish_n_in,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic             burst_n_out,
    output logic [14:0]      address_out,
    output logic [3:0]       lanes_out,
    output logic             busy_out
);
    logic rd_r   = 1'b1;
    logic drop_h = 1'b0;
    int   words  = 0;

    initial begin
        wr_n_out    = 1'b1;
        burst_n_out = 1'b1;
        address_out = 15'h0000;
        lanes_out   = 4'hF;
        busy_out    = 1'b0;
    end

    assign rd_n_out = rd_r | drop_h;

    // The read strobe drops half a cycle after a bus fault is seen.
    always @(negedge clk_in) begin
        drop_h <= busy_out & (drop_h | (fault_n_in === 1'b0));
    end

    // With hold_in set the strobes stay down until the cycle finish, except the read strobe after a bus fault, as a late processor would.
    always @(posedge clk_in) begin
        if (go_in) begin
            busy_out    <= 1'b1;
            address_out <= addr_in;
            lanes_out   <= lanes_in;
            burst_n_out <= ~burst_in;
            rd_r        <= wr_in;
            wr_n_out    <= ~wr_in;
            words       <= 0;
        end else if (busy_out) begin
            if (accept_n_in === 1'b0) begin
                words <= words + 1;
            end
            if (!hold_in && ((accept_n_in === 1'b0 && words + 1 >= (burst_n_out ? 1 : 4))
                    || ack_n_in === 1'b0)) begin
                rd_r     <= 1'b1;
                wr_n_out <= 1'b1;
            end
            if (finish_n_in === 1'b0) begin
                rd_r        <= 1'b1;
                wr_n_out    <= 1'b1;
                burst_n_out <= 1'b1;
                busy_out    <= 1'b0;
            end
        end else begin
            address_out <= ~address_out;
            lanes_out   <= ~lanes_out;
        end
    end
endmodule : mwsc_cpu_model
`default_nettype wire

/* File: memory_wait_state_controller_bench.sv */
// Purpose: Self-checking bench for the wait-state controller against a processor model.
// Assumes: Default top parameters; cycle timings are measured from the launch edge.
// Notes:   Synchroniser latency varies, so delays are taken relative to launch, or to the bus fault for undecoded cycles.
`timescale 1ns/1ps
`default_nettype none
module memory_wait_state_controller_bench;
    import mwsc_pkg::*;
    logic        mclk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        test_en = 1'b0;
    logic        go = 1'b0;
    logic        op_wr = 1'b0;
    logic        op_bst = 1'b0;
    logic        op_hold = 1'b0;
    logic [14:0] op_addr = 15'h0000;
    logic [3:0]  op_ln = 4'hF;
    wire logic   rd_n, wr_n, burst_n, busy, acc_n, ack_n, flt_n, fin_n, lau_n, rde_n, wre_n;
    wire logic [14:0] addr;
    wire logic [3:0]  lanes, bsp_n;
    wire logic [5:0]  cs_n, cs_oe_n;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int lau, fin, flt;
    int acc_t[$];
    int ack_t[$];
    logic [5:0] cs_s;
    logic [6:0] en_s;
    logic [2:0] end_s;

    always #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) cyc <= cyc + 1;

    mwsc_cpu_model u_cpu (.clk_in(mclk_in), .go_in(go), .wr_in(op_wr), .burst_in(op_bst),
        .hold_in(op_hold), .addr_in(op_addr), .lanes_in(op_ln), .accept_n_in(acc_n),
        .ack_n_in(ack_n), .fault_n_in(flt_n), .finish_n_in(fin_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .burst_n_out(burst_n), .address_out(addr), .lanes_out(lanes),
        .busy_out(busy));

    mwsc_top u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1), .address_in(addr),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .burst_n_in(burst_n), .byte_lane_select_n_in(lanes),
        .test_en_in(test_en), .cs_n_out(cs_n), .cs_oe_n_out(cs_oe_n),
        .read_word_accept_n_out(acc_n), .ack_n_out(ack_n), .bus_fault_n_out(flt_n),
        .cycle_finish_n_out(fin_n), .byte_enable_launch_n_out(lau_n),
        .mem_read_en_n_out(rde_n), .mem_write_en_n_out(wre_n),
        .byte_store_pulse_n_out(bsp_n));

    // Outputs except the chip selects and their output enables are registered, so the falling edge sees them settled.
    always @(negedge mclk_in) begin
        if (lau < 0 && lau_n === 1'b0) begin
            lau  = cyc;
            cs_s = cs_n;
            en_s = {rde_n, wre_n, bsp_n, 1'b0};
        end
        if (acc_n === 1'b0) acc_t.push_back(cyc);
        if (ack_n === 1'b0) ack_t.push_back(cyc);
        if (flt_n === 1'b0) begin
            flt  = cyc;
            cs_s = cs_n;
        end
        if (fin < 0 && fin_n === 1'b0) begin
            fin   = cyc;
            end_s = {lau_n, rde_n, wre_n};
        end
    end

    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk_sig

    task automatic chk_num(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk_num

    task automatic run_op(input logic [14:0] a, input bit w, input bit b, input bit h,
                          input logic [3:0] ln);
        int n;
        acc_t.delete();
        ack_t.delete();
        lau = -1;
        fin = -1;
        flt = -1;
        @(posedge mclk_in);
        {go, op_addr, op_wr, op_bst, op_hold, op_ln} <= {1'b1, a, w, b, h, ln};
        @(posedge mclk_in);
        go <= 1'b0;
        n = 0;
        while (fin < 0 && n < 200) begin
            @(posedge mclk_in);
            n++;
        end
        if (fin < 0) begin
            $display("Error at %0t: got %h expected %h", $time, 0, 1);
            err_count++;
            wrap_up();
        end
        // Lets the strobe negation pass the synchroniser before the next start.
        repeat (6) @(posedge mclk_in);
        #1 chk_sig({acc_n, ack_n, flt_n, fin_n, lau_n}, 16'h001F);
    endtask : run_op

    task automatic t_reset_idle();
        @(negedge mclk_in);
        chk_sig({acc_n, ack_n, flt_n, fin_n, lau_n, rde_n, wre_n, bsp_n}, 16'h07FF);
    endtask : t_reset_idle

    task automatic t_test_enable();
        @(posedge mclk_in) test_en <= 1'b1;
        @(negedge mclk_in) chk_sig(cs_oe_n, 16'h003F);
        @(posedge mclk_in) test_en <= 1'b0;
        @(negedge mclk_in) chk_sig(cs_oe_n, 16'h0000);
    endtask : t_test_enable

    task automatic t_reads(input int i, input bit b);
        int f;
        int g;
        f = FIRST_WAIT[i];
        g = WORD_GAP[i];
        run_op(CS_BASE[i], 1'b0, b, 1'b0, 4'h0);
        chk_sig(cs_s, 16'h003F ^ (16'h0001 << i));
        chk_sig(en_s[6:5], 16'h0001);
        chk_num(acc_t.size(), b ? 4 : 1);
        for (int k = 0; k < acc_t.size(); k++) begin
            chk_num(acc_t[k] - lau, f - 1 + k * g);
        end
        chk_num(fin - lau, b ? f + 3 * g : f);
        chk_sig(end_s, 16'h0007);
        chk_num(ack_t.size(), b ? 1 : 0);
        if (b && ack_t.size() == 1 && acc_t.size() == 4) chk_num(ack_t[0], acc_t[3]);
    endtask : t_reads

    task automatic t_writes(input int i, input bit h, input logic [3:0] ln);
        int f;
        f = FIRST_WAIT[i];
        run_op(CS_BASE[i], 1'b1, 1'b0, h, ln);
        chk_sig(cs_s, 16'h003F ^ (16'h0001 << i));
        chk_sig(en_s, {1'b1, 1'b0, ln, 1'b0});
        chk_num(acc_t.size(), 0);
        chk_num(ack_t.size(), 1);
        if (ack_t.size() == 1) chk_num(ack_t[0] - lau, f - 1);
        chk_num(fin - lau, f);
    endtask : t_writes

    task automatic t_undecoded();
        run_op(15'h1234, 1'b0, 1'b0, 1'b0, 4'h0);
        chk_sig(cs_s, 16'h003F);
        chk_num(acc_t.size() + ack_t.size(), 0);
        chk_num(fin - flt, 1);
    endtask : t_undecoded

    initial begin
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        t_reset_idle();
        t_test_enable();
        for (int i = 0; i < NUM_CS; i++) t_reads(i, 1'b0);
        t_reads(0, 1'b1);
        t_reads(3, 1'b1);
        t_writes(0, 1'b0, 4'hE);
        t_writes(1, 1'b0, 4'h5);
        t_writes(2, 1'b0, 4'h0);
        t_writes(4, 1'b1, 4'h3);
        t_undecoded();
        t_reads(1, 1'b0);
        wrap_up();
    end
endmodule : memory_wait_state_controller_bench
`default_nettype wire
